//--- cpu_instruction_execute.sv
// instruction execute core with device halt handshake and apb register access
`timescale 1ns/10ps
module cpu_instruction_execute
    import cpu_exec_pkg::*;
#(
    parameter int W = WORD_W // word width
)
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [PADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic [W-1:0] mem_addr, // core memory address
    output logic mem_rd, // read strobe, data next cycle after taken
    output logic mem_wr, // write strobe
    output logic [W-1:0] mem_wdata, // write data
    input wire logic [W-1:0] mem_rdata, // read data
    input wire logic io_halt_pulse, // device halt from selector
    input wire logic io_restart_pulse, // device done, resume
    output logic iot_strobe, // io instruction pulse to selectors
    output logic [W-1:0] iot_code, // io instruction word
    output logic [W-1:0] sum_register, // sum register levels to devices
    output logic run // run flip-flop
);

    ////////////////////////////////////////////////////////////////////
    // state and next values

    cpu_state_t state, next_state; // sequencer
    logic [W-1:0] instr, next_instr; // instruction being executed
    logic [W-1:0] cur_pc, next_cur_pc; // address of that instruction
    logic [W-1:0] program_counter, next_pc; // next instruction address
    logic [W-1:0] next_sum; // sum register next
    logic link, next_link; // carry bit
    logic device_wait_halt, next_wait; // device halt flag
    logic next_run; // run next
    logic [W-1:0] switch_register, next_switch; // front panel switches
    logic [CNT_W-1:0] elapsed, next_elapsed; // cycles since fetch
    logic [CNT_W-1:0] limit, next_limit; // cycles for this instruction
    logic [W-1:0] next_mem_addr, next_mem_wdata; // memory port next
    logic next_mem_rd, next_mem_wr; // strobes next
    logic next_iot_strobe; // io pulse next
    logic [W-1:0] next_iot_code; // io word next
    logic [31:0] next_prdata, rd_word; // apb read path
    logic lat, next_lat; // read data latched for this transfer

    // decode helpers
    logic [W-1:0] dec_word; // word being decoded this cycle
    logic [2:0] opc; // its opcode
    logic [W-1:0] ea; // its operand address
    logic [W-1:0] u_sum; // operate result
    logic u_link, u_skip, u_halt; // operate side results
    logic bus_wr, addr_ok, start_wr; // apb decode

    ////////////////////////////////////////////////////////////////////
    // functions

    // counter step, wraps at word width
    function automatic logic [W-1:0] inc(input logic [W-1:0] v);
        return v + 1'b1;
    endfunction

    // page zero or current page of the instruction
    function automatic logic [W-1:0] eff_addr(input logic [W-1:0] iw,
                                              input logic [W-1:0] here);
        logic [W-1:0] a;
        a = '0;
        a[OFF_W-1:0] = iw[OFF_W-1:0];
        if (iw[PAGE_BIT]) a[W-1:OFF_W] = here[W-1:OFF_W];
        return a;
    endfunction

    // whole instruction time in clock cycles
    function automatic logic [CNT_W-1:0] instr_cycles(input logic [2:0] op);
        case (op)
            OP_AND, OP_TAD, OP_ISZ, OP_DCA: return CNT_W'(CYC_MEMREF);
            OP_JMS: return CNT_W'(CYC_JMS);
            default: return CNT_W'(CYC_SHORT);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // decode and operate datapath

    // the fetched word is only on mem_rdata during decode
    assign dec_word = (state == S_DECODE) ? mem_rdata : instr;
    assign opc = dec_word[OPC_LSB +: 3];
    assign ea = eff_addr(dec_word, cur_pc);

    operate_unit #(
        .W(W)
    ) u_operate (
        .instr_word(dec_word),
        .sum_in(sum_register),
        .link_in(link),
        .switch_in(switch_register),
        .sum_out(u_sum),
        .link_out(u_link),
        .skip(u_skip),
        .halt(u_halt)
    );

    ////////////////////////////////////////////////////////////////////
    // apb slave decode, zero wait once read data is latched

    assign bus_wr = psel && penable && pwrite && pready;
    assign start_wr = bus_wr && paddr == REG_CTRL && pwdata[CTRL_START];
    assign addr_ok = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_SUM
        || paddr == REG_PC || paddr == REG_SWITCH || paddr == REG_INSTR;
    // low in any frozen cycle, plus one extra cycle when the setup phase fell in a frozen cycle
    assign pready = ce && penable && lat;
    assign pslverr = psel && penable && !addr_ok;

    // read mux; control strobes read back as zero
    always_comb
    begin
        rd_word = '0;
        case (paddr)
            REG_STATUS:
            begin
                rd_word[STAT_RUN] = run;
                rd_word[STAT_WAIT] = device_wait_halt;
                rd_word[STAT_LINK] = link;
                rd_word[STAT_IDLE] = state == S_IDLE;
            end
            REG_SUM: rd_word[W-1:0] = sum_register;
            REG_PC: rd_word[W-1:0] = program_counter;
            REG_SWITCH: rd_word[W-1:0] = switch_register;
            REG_INSTR: rd_word[W-1:0] = instr;
            default: rd_word = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next-state logic for the whole core

    always_comb
    begin
        next_state = state;
        next_instr = instr;
        next_cur_pc = cur_pc;
        next_pc = program_counter;
        next_sum = sum_register;
        next_link = link;
        next_wait = device_wait_halt;
        next_run = run;
        next_switch = switch_register;
        next_elapsed = elapsed + 1'b1;
        next_limit = limit;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_mem_rd = 1'b0;
        next_mem_wr = 1'b0;
        next_iot_strobe = 1'b0;
        next_iot_code = iot_code;
        next_prdata = psel ? rd_word : prdata;
        next_lat = psel && !(penable && pready);

        // instruction sequencer
        case (state)
            S_IDLE:
            begin
                next_elapsed = '0;
                if (run) next_state = S_FETCH;
            end
            S_FETCH:
            begin
                next_mem_addr = program_counter;
                next_mem_rd = 1'b1;
                next_cur_pc = program_counter;
                next_pc = inc(program_counter);
                next_state = S_FWAIT;
            end
            S_FWAIT: next_state = S_DECODE;
            S_DECODE:
            begin
                next_instr = mem_rdata;
                next_limit = instr_cycles(opc);
                next_state = S_HOLD;
                case (opc)
                    OP_AND, OP_TAD, OP_ISZ:
                    begin
                        // operand read, result in exec
                        next_mem_addr = ea;
                        next_mem_rd = 1'b1;
                        next_state = S_OWAIT;
                    end
                    OP_DCA:
                    begin
                        next_mem_addr = ea;
                        next_mem_wdata = sum_register;
                        next_mem_wr = 1'b1;
                        next_sum = '0;
                    end
                    OP_JMS:
                    begin
                        // return address is the already advanced counter
                        next_mem_addr = ea;
                        next_mem_wdata = program_counter;
                        next_mem_wr = 1'b1;
                        next_pc = inc(ea);
                    end
                    OP_JMP: next_pc = ea;
                    OP_IOT:
                    begin
                        // selectors decode this and may answer with a halt
                        next_iot_strobe = 1'b1;
                        next_iot_code = mem_rdata;
                    end
                    default:
                    begin
                        next_sum = u_sum;
                        next_link = u_link;
                        if (u_skip) next_pc = inc(program_counter);
                        if (u_halt) next_run = 1'b0;
                    end
                endcase
            end
            S_OWAIT: next_state = S_EXEC;
            S_EXEC:
            begin
                next_state = S_HOLD;
                case (instr[OPC_LSB +: 3])
                    OP_AND: next_sum = sum_register & mem_rdata;
                    OP_TAD: next_sum = sum_register + mem_rdata;
                    default:
                    begin
                        // index: write back, skip when it wrapped to zero
                        next_mem_wdata = inc(mem_rdata);
                        next_mem_wr = 1'b1;
                        if (inc(mem_rdata) == '0) next_pc = inc(program_counter);
                    end
                endcase
            end
            S_HOLD:
            begin
                // pad out to the full instruction time
                if (elapsed >= limit - 1'b1)
                begin
                    next_elapsed = '0;
                    next_state = run ? S_FETCH : S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase

        // software access; machine state only while stopped
        if (bus_wr)
        begin
            case (paddr)
                REG_CTRL:
                begin
                    if (pwdata[CTRL_START] && !device_wait_halt) next_run = 1'b1;
                    if (pwdata[CTRL_STOP]) next_run = 1'b0;
                end
                REG_SUM: if (state == S_IDLE) next_sum = pwdata[W-1:0];
                REG_PC: if (state == S_IDLE) next_pc = pwdata[W-1:0];
                REG_SWITCH: next_switch = pwdata[W-1:0];
                default: next_switch = switch_register;
            endcase
        end

        // device halt handshake; a halt in the restart cycle wins
        if (device_wait_halt && io_restart_pulse)
        begin
            next_wait = 1'b0;
            next_run = 1'b1;
        end
        if (io_halt_pulse) next_wait = 1'b1;
        if (next_wait) next_run = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= S_IDLE;
            instr <= '0;
            cur_pc <= '0;
            program_counter <= '0;
            sum_register <= '0;
            link <= 1'b0;
            device_wait_halt <= 1'b0;
            run <= 1'b0;
            switch_register <= '0;
            elapsed <= '0;
            limit <= '0;
            mem_addr <= '0;
            mem_wdata <= '0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            iot_strobe <= 1'b0;
            iot_code <= '0;
            prdata <= '0;
            lat <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            instr <= next_instr;
            cur_pc <= next_cur_pc;
            program_counter <= next_pc;
            sum_register <= next_sum;
            link <= next_link;
            device_wait_halt <= next_wait;
            run <= next_run;
            switch_register <= next_switch;
            elapsed <= next_elapsed;
            limit <= next_limit;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            mem_rd <= next_mem_rd;
            mem_wr <= next_mem_wr;
            iot_strobe <= next_iot_strobe;
            iot_code <= next_iot_code;
            prdata <= next_prdata;
            lat <= next_lat;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_dec(logic [2:0] op);
        ce && state == S_DECODE && mem_rdata[OPC_LSB +: 3] == op;
    endsequence

    sequence s_exec(logic [2:0] op);
        ce && state == S_EXEC && instr[OPC_LSB +: 3] == op;
    endsequence

    halt_sets_wait_a: assert property (
        ce && io_halt_pulse |=> device_wait_halt)
        else $error("device halt did not set the wait flag");
    wait_stops_run_a: assert property (
        ce && device_wait_halt && !io_restart_pulse |=> !run)
        else $error("run stayed set during device wait");
    restart_resumes_a: assert property (
        ce && device_wait_halt && io_restart_pulse && !io_halt_pulse
        |=> run && !device_wait_halt)
        else $error("restart did not resume the program");
    restart_gated_a: assert property (
        ce && !device_wait_halt && !run && io_restart_pulse && !start_wr |=> !run)
        else $error("restart acted without device wait");
    and_result_a: assert property (
        s_exec(OP_AND) |=> sum_register == $past(sum_register & mem_rdata))
        else $error("logical product wrong");
    add_result_a: assert property (
        s_exec(OP_TAD) |=> sum_register == $past(sum_register + mem_rdata))
        else $error("add result wrong");
    index_skip_a: assert property (
        s_exec(OP_ISZ) && mem_rdata == '1 |=> mem_wr && mem_wdata == '0
        && program_counter == inc($past(program_counter)))
        else $error("index to zero did not skip");
    deposit_clear_a: assert property (
        s_dec(OP_DCA) |=> mem_wr && mem_wdata == $past(sum_register) && sum_register == '0)
        else $error("deposit and clear wrong");
    call_link_a: assert property (
        s_dec(OP_JMS) |=> mem_wr && mem_wdata == $past(program_counter)
        && program_counter == inc(mem_addr) && limit == CNT_W'(CYC_JMS))
        else $error("subroutine call wrong");
    jump_target_a: assert property (
        s_dec(OP_JMP) |=> program_counter == $past(ea))
        else $error("jump target wrong");
    nop_time_a: assert property (
        s_dec(OP_OPR) && mem_rdata == NOP_CODE
        |=> limit == CNT_W'(CYC_SHORT) && sum_register == $past(sum_register))
        else $error("no-op time or effect wrong");
    halt_code_a: assert property (
        s_dec(OP_OPR) && mem_rdata == HLT_CODE && !io_restart_pulse && !start_wr |=> !run)
        else $error("halt code did not stop the program");

endmodule

//--- cpu_exec_pkg.sv
// constants, types and register map shared by the instruction execute block
package cpu_exec_pkg;

    // clock and instruction timing
    localparam int CLK_PERIOD_NS = 50; // pclk period at 20 MHz
    localparam int NS_PER_US = 1000; // unit conversion
    localparam int T_MEMREF_US = 18; // and, tad, isz, dca
    localparam int T_JMS_US = 24; // subroutine call
    localparam int T_SHORT_US = 12; // jmp, operate, iot

    // least time rounds up to whole cycles
    function automatic int us_to_cycles(input int us);
        return (us * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    localparam int CYC_MEMREF = us_to_cycles(T_MEMREF_US); // cycles per memory-ref op
    localparam int CYC_JMS = us_to_cycles(T_JMS_US); // cycles per call
    localparam int CYC_SHORT = us_to_cycles(T_SHORT_US); // cycles per short op
    localparam int CNT_W = $clog2(CYC_JMS + 1); // instruction timer width

    // word layout
    localparam int WORD_W = 12; // machine word width
    localparam int OPC_LSB = 9; // opcode field low bit, 3 bits wide
    localparam int GROUP_BIT = 8; // operate group select
    localparam int PAGE_BIT = 7; // current page select
    localparam int OFF_W = 7; // page offset width

    // opcodes
    localparam logic [2:0] OP_AND = 3'h0;
    localparam logic [2:0] OP_TAD = 3'h1;
    localparam logic [2:0] OP_ISZ = 3'h2;
    localparam logic [2:0] OP_DCA = 3'h3;
    localparam logic [2:0] OP_JMS = 3'h4;
    localparam logic [2:0] OP_JMP = 3'h5;
    localparam logic [2:0] OP_IOT = 3'h6;
    localparam logic [2:0] OP_OPR = 3'h7;

    // group one micro-operation bits
    localparam int G1_CLA = 7;
    localparam int G1_CLL = 6;
    localparam int G1_CMA = 5;
    localparam int G1_CML = 4;
    localparam int G1_RAR = 3;
    localparam int G1_RAL = 2;
    localparam int G1_TWICE = 1;
    localparam int G1_IAC = 0;

    // group two micro-operation bits
    localparam int G2_CLA = 7;
    localparam int G2_SMA = 6;
    localparam int G2_SZA = 5;
    localparam int G2_SNL = 4;
    localparam int G2_REV = 3;
    localparam int G2_OSR = 2;
    localparam int G2_HLT = 1;

    // whole-word codes used by checks
    localparam logic [WORD_W-1:0] NOP_CODE = 12'he00;
    localparam logic [WORD_W-1:0] HLT_CODE = 12'hf02;

    // apb register map (byte addresses)
    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [PADDR_W-1:0] REG_SUM = 12'h008;
    localparam logic [PADDR_W-1:0] REG_PC = 12'h00c;
    localparam logic [PADDR_W-1:0] REG_SWITCH = 12'h010;
    localparam logic [PADDR_W-1:0] REG_INSTR = 12'h014;

    // control and status bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int STAT_RUN = 0;
    localparam int STAT_WAIT = 1;
    localparam int STAT_LINK = 2;
    localparam int STAT_IDLE = 3;

    // sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_FETCH,
        S_FWAIT,
        S_DECODE,
        S_OWAIT,
        S_EXEC,
        S_HOLD
    } cpu_state_t;

endpackage

//--- operate_unit.sv
// operate micro-instruction datapath: clears, rotates, skips, switch or
`timescale 1ns/10ps
module operate_unit
    import cpu_exec_pkg::*;
#(
    parameter int W = WORD_W // word width
)
(
    input wire logic [W-1:0] instr_word, // operate instruction
    input wire logic [W-1:0] sum_in, // current sum register
    input wire logic link_in, // current carry bit
    input wire logic [W-1:0] switch_in, // front panel switches
    output logic [W-1:0] sum_out, // new sum register
    output logic link_out, // new carry bit
    output logic skip, // skip next instruction
    output logic halt // stop the program
);

    // msb of the vector is bit 0 of the machine word
    always_comb
    begin
        logic [W-1:0] a;
        logic l;
        logic cond;
        a = sum_in;
        l = link_in;
        cond = 1'b0;
        skip = 1'b0;
        halt = 1'b0;
        if (!instr_word[GROUP_BIT])
        begin
            // clears first, then complements and rotates, increment last
            if (instr_word[G1_CLA]) a = '0;
            if (instr_word[G1_CLL]) l = 1'b0;
            if (instr_word[G1_CMA]) a = ~a;
            if (instr_word[G1_CML]) l = ~l;
            for (int i = 0; i < 2; i++)
            begin
                // second pass only for the two-place forms
                if (i == 0 || instr_word[G1_TWICE])
                begin
                    if (instr_word[G1_RAR])
                        {l, a} = {a[0], l, a[W-1:1]};
                    else if (instr_word[G1_RAL])
                        {l, a} = {a, l};
                end
            end
            if (instr_word[G1_IAC]) a = a + 1'b1;
        end
        else
        begin
            // tests look at the word before any clear of this instruction
            cond = (instr_word[G2_SMA] && a[W-1])
                || (instr_word[G2_SZA] && a == '0)
                || (instr_word[G2_SNL] && l);
            skip = instr_word[G2_REV] ? !cond : cond;
            if (instr_word[G2_CLA]) a = '0;
            if (instr_word[G2_OSR]) a = a | switch_in;
            halt = instr_word[G2_HLT];
        end
        sum_out = a;
        link_out = l;
    end

endmodule

//--- core_mem_model.sv
// core memory and device selector partner for the execute block
`timescale 1ns/10ps
module core_mem_model
    import cpu_exec_pkg::*;
#(
    parameter int BUSY_CYC = 300 // device operation length, plain default
)
(
    input wire logic pclk, // system clock
    input wire logic [WORD_W-1:0] mem_addr, // word address
    input wire logic mem_rd, // read strobe
    input wire logic mem_wr, // write strobe
    input wire logic [WORD_W-1:0] mem_wdata, // write data
    output logic [WORD_W-1:0] mem_rdata, // read data
    input wire logic iot_strobe, // io instruction pulse
    output logic io_halt_pulse, // halt back to core
    output logic io_restart_pulse // device done
);
    logic [WORD_W-1:0] cells [0:4095]; // core array
    int busy = 0; // cycles left in device work
    initial
    begin
        mem_rdata = '0;
        io_halt_pulse = 1'b0;
        io_restart_pulse = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // read data stands one cycle, then turns over so stale data shows
    always @(posedge pclk)
    begin
        if (mem_wr)
            cells[mem_addr] <= mem_wdata;
        mem_rdata <= mem_rd ? cells[mem_addr] : ~mem_rdata;
        io_halt_pulse <= iot_strobe;
        io_restart_pulse <= (busy == 1);
        busy <= iot_strobe ? BUSY_CYC : (busy > 0 ? busy - 1 : 0);
    end
endmodule

//--- cpu_instruction_execute_tb_top.sv
// self-checking bench for the instruction execute block
`timescale 1ns/10ps
`define CHECK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("mismatch at %0t: value differs", $time); \
        end \
    end
module cpu_instruction_execute_tb_top
    import cpu_exec_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0; // bus
    logic [PADDR_W-1:0] paddr = '0; // byte address
    logic [31:0] pwdata = '0, prdata, rd_data; // data words
    logic pready, pslverr, rd_err, mem_rd, mem_wr, iot_strobe, run; // flags
    logic io_halt_pulse, io_restart_pulse; // device handshake
    logic [WORD_W-1:0] mem_addr, mem_wdata, mem_rdata, sum_register, iot_code; // words
    int err_total = 0, n_compared = 0, cycles = 0; // counters
    // program at 010 and subroutine page at 050
    logic [11:0] p1 [0:13] = '{12'h240, 12'h041, 12'h442, 12'hf02, 12'h643,
        12'hf04, 12'hf20, 12'hf40, 12'hf02, 12'he04, 12'hf10, 12'hf02, 12'he08, 12'h850};
    logic [11:0] p2 [0:9] = '{12'h000, 12'he0a, 12'ha55, 12'hf02, 12'hf02,
        12'hf18, 12'hf02, 12'hc19, 12'he00, 12'hf02};
    cpu_instruction_execute dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .io_halt_pulse(io_halt_pulse), .io_restart_pulse(io_restart_pulse),
        .iot_strobe(iot_strobe), .iot_code(iot_code), .sum_register(sum_register), .run(run));
    core_mem_model mem (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .iot_strobe(iot_strobe), .io_halt_pulse(io_halt_pulse),
        .io_restart_pulse(io_restart_pulse));
    initial
    begin
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    // one apb transfer; pready and read data taken at the rising edge that ends it
    // the leading edge keeps back-to-back calls from driving psel twice in one step
    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll status until the masked bits match
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        rd_data = '0;
        do apb(1'b0, REG_STATUS, '0); while ((rd_data & m) !== v);
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, the program needs about 4900 cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            give_verdict();
        end
    end
    initial
    begin
        for (int i = 0; i < 4096; i++) mem.cells[i] = '0;
        foreach (p1[i]) mem.cells[12'h010 + i] = p1[i];
        foreach (p2[i]) mem.cells[12'h050 + i] = p2[i];
        mem.cells[12'h040] = 12'h0f3;
        mem.cells[12'h041] = 12'h0a5;
        mem.cells[12'h042] = 12'hfff;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'hff0, '0);
        `CHECK(rd_err, 1'b1)
        $display("test bus refusal done");
        apb(1'b1, REG_SWITCH, 32'h0000_0800);
        apb(1'b1, REG_PC, 32'h0000_0010);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        poll(32'h0000_0002, 32'h0000_0002);
        `CHECK(rd_data[STAT_RUN], 1'b0)
        poll(32'h0000_000b, 32'h0000_0008);
        `CHECK(rd_data[STAT_LINK], 1'b0)
        apb(1'b0, REG_SUM, '0);
        `CHECK(rd_data, 32'h0000_0200)
        `CHECK(mem.cells[12'h042], 12'h000)
        `CHECK(mem.cells[12'h043], 12'h0a1)
        `CHECK(mem.cells[12'h050], 12'h01e)
        `CHECK(sum_register, 12'h200)
        `CHECK(run, 1'b0)
        `CHECK(iot_code, 12'hc19)
        apb(1'b0, REG_INSTR, '0);
        `CHECK(rd_data, 32'h0000_0f02)
        apb(1'b0, REG_PC, '0);
        `CHECK(rd_data, 32'h0000_005a)
        $display("test program run done");
        give_verdict();
    end
endmodule
